// [hw/ltd_pkg.sv]
// ltd_pkg: constants and types for the low pin count target front end.
// assumes a single 200 MHz core clock; the link clock is sampled as data.
`default_nettype none
package ltd_pkg;
  // ----------------------------------------
  // link field encodings
  // ----------------------------------------
  localparam logic [3:0] LAD_START = 4'h0;
  localparam logic [3:0] SYNC_READY = 4'h0;
  localparam logic [3:0] SYNC_SHORT = 4'h5;
  localparam logic [3:0] SYNC_LONG = 4'h6;
  localparam logic [3:0] TAR_NIB = 4'hF;
  localparam logic [1:0] CT_IO = 2'h0;
  localparam logic [1:0] CT_DMA = 2'h2;
  localparam logic [1:0] SIZE_1B = 2'h0;
  // ----------------------------------------
  // wait states and counts
  // ----------------------------------------
  localparam logic [2:0] IO_RD_WAITS = 3'h3;
  localparam logic [2:0] IO_WR_WAITS = 3'h2;
  localparam logic [2:0] DMA_RD_WAITS = 3'h3;
  localparam logic [2:0] DMA_WR_WAITS = 3'h4;
  localparam logic [2:0] ADDR_LAST = 3'h3;
  localparam logic [2:0] LDRQ_BITS = 3'h6;
  // ----------------------------------------
  // synchronised pin positions and reset
  // ----------------------------------------
  localparam int P_LCLK = 0;
  localparam int P_FRAME = 1;
  localparam int P_IRST = 2;
  localparam int P_PD = 3;
  localparam int P_SG = 4;
  localparam int P_LAD = 5;
  localparam int NPIN = 9;
  localparam logic [8:0] PIN_RST = 9'h00E;
  // ----------------------------------------
  // decoded blocks, default bases, spans
  // ----------------------------------------
  localparam int BLK_FDC = 0;
  localparam int BLK_SER1 = 1;
  localparam int BLK_SER2 = 2;
  localparam int BLK_PAR = 3;
  localparam int BLK_GAME = 4;
  localparam int BLK_RT = 5;
  localparam int BLK_MIDI = 6;
  localparam int BLK_CFG = 7;
  localparam int NBLK = 8;
  localparam logic [127:0] BASE_DEF = {16'h002E, 16'h0330, 16'h0800, 16'h0201,
                                       16'h0378, 16'h02F8, 16'h03F8, 16'h03F0};
  localparam logic [6:0] SPAN_FDC = 7'h06;
  localparam logic [15:0] FDC_HI_OFF = 16'h0007;
  localparam logic [6:0] SPAN_SER = 7'h08;
  localparam logic [6:0] SPAN_PAR = 7'h04;
  localparam logic [6:0] SPAN_PAR_EPP = 7'h08;
  localparam logic [15:0] PAR_ECP_OFF = 16'h0400;
  localparam logic [6:0] SPAN_ECP = 7'h03;
  localparam logic [6:0] SPAN_GAME = 7'h01;
  localparam logic [6:0] SPAN_RT = 7'h60;
  localparam logic [6:0] SPAN_PAIR = 7'h02;
  // ----------------------------------------
  // cycle states, gray along the usual path
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CT = 4'h1,
    ST_ADDR = 4'h3,
    ST_CHAN = 4'h2,
    ST_HDATA = 4'h6,
    ST_TAR1 = 4'h7,
    ST_TAR2 = 4'h5,
    ST_SYNC = 4'h4,
    ST_DDATA = 4'hC,
    ST_DTAR = 4'hD,
    ST_IGN = 4'hF
  } ltd_state_t;
endpackage : ltd_pkg
`default_nettype wire

// [hw/ltd_lpc_target.sv]
// ltd_lpc_target: low pin count target front end with window decode.
// assumes link pins arrive asynchronously; inner blocks run on mclk_in.
//
// Behaviour
// - registers are bytes via io or dma
// - only io/dma read/write, one byte each
// - unsupported cycles ignored, no drive, no change
// - everything multiplexed on the lad nibble bus
// - interface reset pin resets the link logic
// - dma request sent as serial encoded line
// - wake events pull open-drain wake line low
// - powerdown input floats and idles the link
// - no clock run pin, no clock negotiation
// - supply good low disables all decoding
// - wake path keeps working without supply good
// - supply good low disables ir timeout
// - relocatable bases, defaults after power-up
// - floppy at offsets 0-5 and 7
// - serial ports each eight offsets
// - game port single address at base
// - runtime block offsets 0 through 5F
// - frame active releases lad next clock
// - io and dma start nibble is 0000
// - reset ignores frame, floats lad, request high
// - io waits: three read, two write, 0110
`timescale 1ns/1ps
`default_nettype none
module ltd_lpc_target
  import ltd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic lclk_in,
  input wire logic interface_reset_n_in,
  input wire logic frame_strobe_n_in,
  input wire logic [3:0] lad_in,
  output logic [3:0] lad_out,
  output logic lad_oe_n_out,
  output logic dma_request_n_out,
  input wire logic link_powerdown_n_in,
  input wire logic supply_good_in,
  input wire logic wake_req_in,
  input wire logic wake_event_n_in,
  output logic wake_event_n_out,
  output logic wake_event_oe_n_out,
  output logic ir_timeout_en_out,
  input wire logic base_wr_in,
  input wire logic [2:0] base_idx_in,
  input wire logic [15:0] base_val_in,
  input wire logic [1:0] par_mode_in,
  input wire logic dma_req_valid_in,
  input wire logic [2:0] dma_req_chan_in,
  input wire logic dma_req_act_in,
  output logic dma_req_ready_out,
  output logic [7:0] blk_sel_out,
  output logic [15:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_strobe_out,
  output logic rd_strobe_out,
  input wire logic [7:0] rdata_in,
  output logic dma_cycle_out,
  output logic [2:0] dma_chan_out
);
  import ltd_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] s3_q;
  logic [NPIN-1:0] pin_q;
  logic lclk_prev_q;
  logic lclk_rise_c;
  logic frame_c;
  logic [3:0] lad_c;
  logic rst_c;
  logic active_c;

  assign pin_raw = {lad_in, supply_good_in, link_powerdown_n_in,
                    interface_reset_n_in, frame_strobe_n_in, lclk_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge mclk_in)
      begin
        if (srst_in)
        begin
          s1_q[gi] <= PIN_RST[gi];
          s2_q[gi] <= PIN_RST[gi];
          s3_q[gi] <= PIN_RST[gi];
          pin_q[gi] <= PIN_RST[gi];
        end
        else
        begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            pin_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      lclk_prev_q <= 1'b0;
    else
      lclk_prev_q <= pin_q[P_LCLK];
  end

  assign lclk_rise_c = pin_q[P_LCLK] && !lclk_prev_q;
  assign frame_c = pin_q[P_FRAME];
  assign lad_c = pin_q[P_LAD +: 4];
  assign rst_c = srst_in || !pin_q[P_IRST];
  assign active_c = pin_q[P_SG] && pin_q[P_PD];

  // ----------------------------------------
  // relocatable base addresses
  // ----------------------------------------
  logic [15:0] base_q [NBLK];

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      for (int i = 0; i < NBLK; i++)
        base_q[i] <= BASE_DEF[i*16 +: 16];
    end
    else if (base_wr_in)
      base_q[base_idx_in] <= base_val_in;
  end

  // ----------------------------------------
  // window decode
  // ----------------------------------------
  function automatic logic in_win(input logic [15:0] a, input logic [15:0] b,
                                  input logic [6:0] n);
    logic [16:0] d;
    d = {1'b0, a} - {1'b0, b};
    in_win = !d[16] && (d < {10'h000, n});
  endfunction : in_win

  logic [15:0] addr_nx_c;
  logic [7:0] dec_c;
  logic [15:0] ecp_base_c;
  logic [15:0] fdc_hi_c;

  assign addr_nx_c = {addr_out[11:0], lad_c};
  assign ecp_base_c = base_q[BLK_PAR] + PAR_ECP_OFF;
  assign fdc_hi_c = base_q[BLK_FDC] + FDC_HI_OFF;

  always_comb
  begin
    dec_c = 8'h00;
    dec_c[BLK_FDC] = in_win(addr_nx_c, base_q[BLK_FDC], SPAN_FDC)
                     || (addr_nx_c == fdc_hi_c);
    dec_c[BLK_SER1] = in_win(addr_nx_c, base_q[BLK_SER1], SPAN_SER);
    dec_c[BLK_SER2] = in_win(addr_nx_c, base_q[BLK_SER2], SPAN_SER);
    dec_c[BLK_PAR] = in_win(addr_nx_c, base_q[BLK_PAR],
                            par_mode_in[0] ? SPAN_PAR_EPP : SPAN_PAR)
                     || (par_mode_in[1]
                         && in_win(addr_nx_c, ecp_base_c, SPAN_ECP));
    dec_c[BLK_GAME] = in_win(addr_nx_c, base_q[BLK_GAME], SPAN_GAME);
    dec_c[BLK_RT] = in_win(addr_nx_c, base_q[BLK_RT], SPAN_RT);
    dec_c[BLK_MIDI] = in_win(addr_nx_c, base_q[BLK_MIDI], SPAN_PAIR);
    dec_c[BLK_CFG] = in_win(addr_nx_c, base_q[BLK_CFG], SPAN_PAIR);
  end

  // ----------------------------------------
  // cycle engine
  // ----------------------------------------
  ltd_state_t st_q;
  logic [2:0] cnt_q;
  logic dir_in_q;
  logic [7:0] rdata_q;
  logic [2:0] waits_c;
  logic [3:0] wait_nib_c;

  assign waits_c = dma_cycle_out ? (dir_in_q ? DMA_RD_WAITS : DMA_WR_WAITS)
                                 : (dir_in_q ? IO_WR_WAITS : IO_RD_WAITS);
  assign wait_nib_c = dma_cycle_out ? SYNC_SHORT : SYNC_LONG;

  always_ff @(posedge mclk_in)
  begin
    wr_strobe_out <= 1'b0;
    rd_strobe_out <= 1'b0;
    if (rst_c || !active_c)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 3'h0;
      dir_in_q <= 1'b0;
      lad_out <= TAR_NIB;
      lad_oe_n_out <= 1'b1;
      blk_sel_out <= 8'h00;
      addr_out <= 16'h0000;
      wdata_out <= 8'h00;
      dma_cycle_out <= 1'b0;
      dma_chan_out <= 3'h0;
    end
    else if (lclk_rise_c)
    begin
      if (!frame_c)
      begin
        lad_oe_n_out <= 1'b1;
        st_q <= (lad_c == LAD_START) ? ST_CT : ST_IDLE;
        blk_sel_out <= 8'h00;
      end
      else
      begin
        case (st_q)
          ST_CT:
          begin
            cnt_q <= 3'h0;
            addr_out <= 16'h0000;
            dma_cycle_out <= lad_c[3];
            dir_in_q <= lad_c[3] ? !lad_c[1] : lad_c[1];
            if (lad_c[3:2] == CT_IO)
              st_q <= ST_ADDR;
            else if (lad_c[3:2] == CT_DMA && !lad_c[0])
              st_q <= ST_CHAN;
            else
              st_q <= ST_IGN;
          end
          ST_ADDR:
          begin
            addr_out <= addr_nx_c;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == ADDR_LAST)
            begin
              cnt_q <= 3'h0;
              blk_sel_out <= dec_c;
              if (dec_c == 8'h00)
                st_q <= ST_IGN;
              else if (dir_in_q)
                st_q <= ST_HDATA;
              else
              begin
                st_q <= ST_TAR1;
                rd_strobe_out <= 1'b1;
              end
            end
          end
          ST_CHAN:
          begin
            cnt_q <= 3'h1;
            if (cnt_q == 3'h0)
              dma_chan_out <= lad_c[2:0];
            else if (lad_c[1:0] != SIZE_1B)
              st_q <= ST_IGN;
            else if (dir_in_q)
            begin
              cnt_q <= 3'h0;
              st_q <= ST_HDATA;
            end
            else
            begin
              st_q <= ST_TAR1;
              rd_strobe_out <= 1'b1;
            end
          end
          ST_HDATA:
          begin
            cnt_q <= 3'h1;
            if (cnt_q == 3'h0)
              wdata_out[3:0] <= lad_c;
            else
            begin
              wdata_out[7:4] <= lad_c;
              wr_strobe_out <= 1'b1;
              st_q <= ST_TAR1;
            end
          end
          ST_TAR1:
            st_q <= ST_TAR2;
          ST_TAR2:
          begin
            st_q <= ST_SYNC;
            cnt_q <= 3'h0;
            lad_oe_n_out <= 1'b0;
            lad_out <= (waits_c != 3'h0) ? wait_nib_c : SYNC_READY;
          end
          ST_SYNC:
          begin
            if (cnt_q == waits_c)
            begin
              cnt_q <= 3'h0;
              if (dir_in_q)
              begin
                st_q <= ST_DTAR;
                lad_out <= TAR_NIB;
              end
              else
              begin
                st_q <= ST_DDATA;
                lad_out <= rdata_q[3:0];
              end
            end
            else
            begin
              cnt_q <= cnt_q + 3'h1;
              lad_out <= (cnt_q + 3'h1 < waits_c) ? wait_nib_c : SYNC_READY;
            end
          end
          ST_DDATA:
          begin
            cnt_q <= 3'h1;
            if (cnt_q == 3'h0)
              lad_out <= rdata_q[7:4];
            else
            begin
              st_q <= ST_DTAR;
              lad_out <= TAR_NIB;
            end
          end
          ST_DTAR:
          begin
            lad_oe_n_out <= 1'b1;
            blk_sel_out <= 8'h00;
            st_q <= ST_IDLE;
          end
          default:
            st_q <= st_q;
        endcase
      end
    end
  end

  // ----------------------------------------
  // read data capture
  // ----------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      rdata_q <= 8'h00;
    else if (rd_strobe_out)
      rdata_q <= rdata_in;
  end

  // ----------------------------------------
  // serial dma request
  // ----------------------------------------
  logic [5:0] dq_sh_q;
  logic [2:0] dq_cnt_q;

  assign dma_req_ready_out = (dq_cnt_q == 3'h0) && active_c && !rst_c;

  always_ff @(posedge mclk_in)
  begin
    if (rst_c || !active_c)
    begin
      dq_sh_q <= 6'h3F;
      dq_cnt_q <= 3'h0;
      dma_request_n_out <= 1'b1;
    end
    else if (dma_req_valid_in && dma_req_ready_out)
    begin
      dq_sh_q <= {1'b1, dma_req_act_in, dma_req_chan_in[0], dma_req_chan_in[1],
                  dma_req_chan_in[2], 1'b0};
      dq_cnt_q <= LDRQ_BITS;
    end
    else if (lclk_rise_c && dq_cnt_q != 3'h0)
    begin
      dma_request_n_out <= dq_sh_q[0];
      dq_sh_q <= {1'b1, dq_sh_q[5:1]};
      dq_cnt_q <= dq_cnt_q - 3'h1;
    end
  end

  // ----------------------------------------
  // standby side: wake line and ir gate
  // ----------------------------------------
  logic wake_q;

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      wake_q <= 1'b0;
    else
      wake_q <= wake_req_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      ir_timeout_en_out <= 1'b0;
    else
      ir_timeout_en_out <= pin_q[P_SG];
  end

  // no clock run request pin exists, so no clock stop handling
  assign wake_event_n_out = 1'b0;
  assign wake_event_oe_n_out = !wake_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb_m @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  property p_rst_float;
    rst_c |=> lad_oe_n_out && dma_request_n_out;
  endproperty
  a_rst_float: assert property (p_rst_float)
    else $error("link driven during interface reset");

  property p_frame_release;
    lclk_rise_c && !frame_c |=> lad_oe_n_out;
  endproperty
  a_frame_release: assert property (p_frame_release)
    else $error("lad still driven after frame seen");

  property p_ign_silent;
    st_q == ST_IGN |-> lad_oe_n_out && !wr_strobe_out && !rd_strobe_out;
  endproperty
  a_ign_silent: assert property (p_ign_silent)
    else $error("ignored cycle caused activity");

  property p_unpowered;
    !pin_q[P_SG] |=> !wr_strobe_out && !rd_strobe_out && lad_oe_n_out;
  endproperty
  a_unpowered: assert property (p_unpowered)
    else $error("decode active without supply good");

  property p_sel_live;
    wr_strobe_out || rd_strobe_out |-> $past(active_c) && !$past(rst_c)
      && (dma_cycle_out || blk_sel_out != 8'h00);
  endproperty
  a_sel_live: assert property (p_sel_live)
    else $error("strobe without decoded cycle");

  property p_io_sync;
    st_q == ST_SYNC && !dma_cycle_out && lad_out != SYNC_READY |-> lad_out == SYNC_LONG;
  endproperty
  a_io_sync: assert property (p_io_sync)
    else $error("wrong io wait pattern");

  property p_one_byte;
    wr_strobe_out |=> !wr_strobe_out [*8];
  endproperty
  a_one_byte: assert property (p_one_byte)
    else $error("more than one byte per cycle");

  property p_pd_idle;
    !pin_q[P_PD] |=> lad_oe_n_out && dma_request_n_out;
  endproperty
  a_pd_idle: assert property (p_pd_idle)
    else $error("link active during powerdown");

  property p_ldrq_start;
    dma_req_valid_in && dma_req_ready_out
      |-> ##[1:20] (!dma_request_n_out || rst_c || !active_c);
  endproperty
  a_ldrq_start: assert property (p_ldrq_start)
    else $error("dma request start bit missing");

  property p_wake;
    wake_req_in [*2] |-> !wake_event_oe_n_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake line not pulled");

  c_io_wr: cover property (wr_strobe_out && !dma_cycle_out);
  c_io_rd: cover property (rd_strobe_out && !dma_cycle_out);
  c_dma: cover property (rd_strobe_out && dma_cycle_out);
  c_ign: cover property (st_q == ST_IGN ##1 !frame_c);
endmodule : ltd_lpc_target
`default_nettype wire

// [bench/ltd_host_model.sv]
// ltd_host_model: host side of the link, one framed cycle per call.
// assumes the bench resolves lad from both enables with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module ltd_host_model
(
  output logic lclk_out,
  output logic frame_n_out,
  output logic [3:0] lad_out,
  output logic lad_oe_out,
  input wire logic [3:0] lad_in
);
  // --------------------
  // clock and cycles
  // --------------------
  initial
  begin
    lclk_out = 1'b0;
    frame_n_out = 1'b1;
    lad_out = 4'hF;
    lad_oe_out = 1'b0;
  end
  always #24 lclk_out = ~lclk_out;
  // nibble launched on the falling edge, sampled on the rising edge
  task automatic put(input logic f, input logic [3:0] n);
    @(negedge lclk_out);
    frame_n_out = f;
    lad_oe_out = 1'b1;
    lad_out = n;
  endtask : put
  // ns stays -1 without a ready sync; cut aborts after the first wait
  task automatic cyc(input logic [3:0] ct, input logic [15:0] a, input logic [7:0] wd,
    input logic cut, output int ns, output logic [3:0] sp, output logic [7:0] rd);
    int i;
    int w;
    logic hd;
    ns = -1;
    w = 0;
    sp = 4'h0;
    rd = 8'h00;
    hd = ct[1] ^ ct[3];
    put(1'b0, 4'h0);
    put(1'b1, ct);
    for (i = ct[3] ? 1 : 3; i >= 0; i--)
      put(1'b1, a[i*4+:4]);
    if (hd)
    begin
      put(1'b1, wd[3:0]);
      put(1'b1, wd[7:4]);
    end
    put(1'b1, 4'hF);
    @(negedge lclk_out);
    lad_oe_out = 1'b0;
    for (i = 0; i < 12 && ns < 0; i++)
    begin
      @(posedge lclk_out);
      if (lad_in === 4'h5 || lad_in === 4'h6)
      begin
        w++;
        sp = lad_in;
      end
      else if (lad_in === 4'h0)
        ns = w;
      if (cut && w > 0)
        break;
    end
    if (ns >= 0 && !hd)
    begin
      @(posedge lclk_out);
      rd[3:0] = lad_in;
      @(posedge lclk_out);
      rd[7:4] = lad_in;
    end
    if (ns < 0)
    begin
      repeat (4) put(1'b0, 4'hF);
      @(negedge lclk_out);
      frame_n_out = 1'b1;
      lad_oe_out = 1'b0;
    end
    else
      repeat (2) @(posedge lclk_out);
  endtask : cyc
endmodule : ltd_host_model
`default_nettype wire

// [bench/ltd_lpc_target_bench.sv]
// ltd_lpc_target_bench: self-checking bench for the link target front end.
// assumes ltd_host_model on the link; lad and wake lines pulled up.
`timescale 1ns/1ps
`default_nettype none
module ltd_lpc_target_bench;
  import ltd_pkg::*;
  typedef struct packed {logic [15:0] a; logic [7:0] sel;} ltd_row_t;
  logic lclk, frame_n, h_oe, dev_oe_n, dq_n, wk_out, wk_oe_n, ir_en, dq_ready, wr_s, rd_s;
  logic dma_cyc;
  logic [3:0] h_lad, dev_lad, s_dc;
  logic [7:0] sel, wdata, s_sel, s_wd;
  logic [15:0] addr, s_addr;
  logic [2:0] dma_chan;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic irst_n = 1'b1;
  logic pd_n = 1'b1;
  logic sg = 1'b1;
  logic wake_req = 1'b0;
  logic base_wr = 1'b0;
  logic [2:0] base_idx = 3'h0;
  logic [15:0] base_val = 16'h0000;
  logic [1:0] par_mode = 2'h0;
  logic dq_valid = 1'b0;
  logic [2:0] dq_chan = 3'h0;
  logic dq_act = 1'b0;
  logic [7:0] rdata = 8'h00;
  int errors = 0;
  int n_tests = 0;
  int n_stb = 0;
  wire logic [3:0] lad_w = !dev_oe_n ? dev_lad : (h_oe ? h_lad : 4'hF);
  wire logic wk_w = wk_oe_n ? 1'b1 : wk_out;
  logic [3:0] bad[6] = '{4'h4, 4'h6, 4'h9, 4'hB, 4'hC, 4'hE};
  ltd_row_t rows[23] = '{{16'h03F0, 8'h01}, {16'h03F5, 8'h01}, {16'h03F6, 8'h00},
    {16'h03F7, 8'h01}, {16'h03F8, 8'h02}, {16'h03FF, 8'h02}, {16'h02F8, 8'h04},
    {16'h02FF, 8'h04}, {16'h0378, 8'h08}, {16'h037B, 8'h08}, {16'h037C, 8'h00},
    {16'h0201, 8'h10}, {16'h0202, 8'h00}, {16'h0800, 8'h20}, {16'h085F, 8'h20},
    {16'h0860, 8'h00}, {16'h0330, 8'h40}, {16'h0331, 8'h40}, {16'h0332, 8'h00},
    {16'h002E, 8'h80}, {16'h002F, 8'h80}, {16'h0030, 8'h00}, {16'h0778, 8'h00}};
  // --------------------
  // design, host and peripheral
  // --------------------
  ltd_host_model host_u (.lclk_out(lclk), .frame_n_out(frame_n), .lad_out(h_lad),
    .lad_oe_out(h_oe), .lad_in(lad_w));
  ltd_lpc_target dut_u (
    .mclk_in(mclk), .srst_in(srst), .lclk_in(lclk), .interface_reset_n_in(irst_n),
    .frame_strobe_n_in(frame_n), .lad_in(lad_w), .lad_out(dev_lad), .lad_oe_n_out(dev_oe_n),
    .dma_request_n_out(dq_n), .link_powerdown_n_in(pd_n), .supply_good_in(sg),
    .wake_req_in(wake_req), .wake_event_n_in(wk_w), .wake_event_n_out(wk_out),
    .wake_event_oe_n_out(wk_oe_n), .ir_timeout_en_out(ir_en), .base_wr_in(base_wr),
    .base_idx_in(base_idx), .base_val_in(base_val), .par_mode_in(par_mode),
    .dma_req_valid_in(dq_valid), .dma_req_chan_in(dq_chan), .dma_req_act_in(dq_act),
    .dma_req_ready_out(dq_ready), .blk_sel_out(sel), .addr_out(addr), .wdata_out(wdata),
    .wr_strobe_out(wr_s), .rd_strobe_out(rd_s), .rdata_in(rdata), .dma_cycle_out(dma_cyc),
    .dma_chan_out(dma_chan));
  always #2.5 mclk = ~mclk;
  always @(posedge mclk)
    if (wr_s === 1'b1 || rd_s === 1'b1)
    begin
      n_stb <= n_stb + 1;
      s_sel <= sel;
      s_addr <= addr;
      s_wd <= wdata;
      s_dc <= {dma_cyc, dma_chan};
    end
  always @(negedge mclk)
    rdata <= dma_cyc ? {5'h15, dma_chan} : addr[7:0] ^ 8'h5A;
  // --------------------
  // tasks
  // --------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle
  // sel_e zero: cycle must be ignored; dma rows use any non-zero value
  task automatic xfer(input logic [3:0] ct, input logic [15:0] a, input logic [7:0] sel_e);
    int ns;
    int n0;
    logic [3:0] sp;
    logic [7:0] rd;
    n0 = n_stb;
    host_u.cyc(ct, a, a[7:0] ^ 8'h3C, 1'b0, ns, sp, rd);
    chk("strobes", {15'h0, sel_e != 8'h00}, 16'(n_stb - n0));
    if (sel_e == 8'h00)
      chk("ignored", 16'hFFFF, ns[15:0]);
    else
    begin
      chk("waits", ct[3] ? (ct[1] ? 16'h4 : 16'h3) : (ct[1] ? 16'h2 : 16'h3), ns[15:0]);
      chk("sync", ct[3] ? 16'h5 : 16'h6, {12'h0, sp});
      if (ct[3])
        chk("dma chan", {12'h0, 1'b1, a[6:4]}, {12'h0, s_dc});
      else
      begin
        chk("select", {8'h0, sel_e}, {8'h0, s_sel});
        chk("address", a, s_addr);
      end
      if (ct[1] ^ ct[3])
        chk("write data", {8'h0, a[7:0] ^ 8'h3C}, {8'h0, s_wd});
      else
        chk("read data", {8'h0, ct[3] ? {5'h15, a[6:4]} : a[7:0] ^ 8'h5A}, {8'h0, rd});
    end
    chk("released", 16'h1, {15'h0, dev_oe_n});
  endtask : xfer
  task automatic dreq(input logic [2:0] c, input logic act);
    logic [4:0] bits;
    int i;
    @(negedge mclk);
    dq_chan = c;
    dq_act = act;
    dq_valid = 1'b1;
    i = 0;
    do
    begin
      @(posedge mclk);
      i++;
    end
    while (dq_ready !== 1'b1 && i < 20);
    @(negedge mclk);
    dq_valid = 1'b0;
    chk("busy", 16'h0, {15'h0, dq_ready});
    for (i = 0; i < 10 && dq_n !== 1'b0; i++)
      @(posedge lclk);
    for (i = 4; i >= 0; i--)
    begin
      @(posedge lclk);
      bits[i] = dq_n;
    end
    chk("request", {11'h0, c, act, 1'b1}, {11'h0, bits});
  endtask : dreq
  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // --------------------
  // sequence
  // --------------------
  initial
  begin
    #300000;
    errors++;
    finish_test();
  end
  initial
  begin
    int ns;
    logic [3:0] sp;
    logic [7:0] rd;
    idle(2);
    srst = 1'b0;
    idle(60);
    foreach (rows[r])
    begin
      xfer(4'h2, rows[r].a, rows[r].sel);
      xfer(4'h0, rows[r].a, rows[r].sel);
    end
    xfer(4'h8, 16'h0010, 8'hFF);
    xfer(4'hA, 16'h0060, 8'hFF);
    xfer(4'h8, 16'h0011, 8'h00);
    foreach (bad[b])
      xfer(bad[b], 16'h03F8, 8'h00);
    @(negedge mclk);
    par_mode = 2'h1;
    xfer(4'h2, 16'h037F, 8'h08);
    @(negedge mclk);
    par_mode = 2'h2;
    xfer(4'h0, 16'h077A, 8'h08);
    xfer(4'h2, 16'h077B, 8'h00);
    xfer(4'h2, 16'h037C, 8'h00);
    @(negedge mclk);
    base_wr = 1'b1;
    base_idx = 3'h2;
    base_val = 16'h0220;
    @(negedge mclk);
    base_wr = 1'b0;
    xfer(4'h2, 16'h0227, 8'h04);
    xfer(4'h0, 16'h02F8, 8'h00);
    @(negedge mclk);
    srst = 1'b1;
    @(negedge mclk);
    chk("reset outputs", 16'h0D00, {4'h0, dev_oe_n, dq_n, ir_en, wk_oe_n, sel});
    srst = 1'b0;
    idle(60);
    xfer(4'h2, 16'h02F8, 8'h04);
    for (int k = 0; k < 3; k++)
    begin
      @(negedge mclk);
      {sg, pd_n, irst_n} = ~(3'h4 >> k);
      wake_req = 1'b1;
      idle(10);
      chk("ir timeout", {15'h0, k != 0}, {15'h0, ir_en});
      chk("wake", 16'h0, {15'h0, wk_w});
      xfer(4'h2, 16'h03F0, 8'h00);
      chk("idle request", 16'h1, {15'h0, dq_n});
      @(negedge mclk);
      {sg, pd_n, irst_n} = 3'h7;
      wake_req = 1'b0;
      idle(60);
      chk("wake off", 16'h1, {15'h0, wk_w});
    end
    host_u.cyc(4'h0, 16'h03F0, 8'h00, 1'b1, ns, sp, rd);
    chk("abort release", 16'h1, {15'h0, dev_oe_n});
    xfer(4'h0, 16'h03F1, 8'h01);
    dreq(3'h5, 1'b1);
    dreq(3'h2, 1'b0);
    finish_test();
  end
endmodule : ltd_lpc_target_bench
`default_nettype wire
